// *** src/flr_ctrl_regs.sv ***
// Overview of operation
// - Read-only design ID at 0x00.
// - Read-only silicon revision at 0x01.
// - 0x02[5:4] picks LED-count comparator reference.
// - 0x02[3:0] flash timer, 100 ms plus 50/step.
// - 0x03[7:4] flash current, 200 mA plus 20/step.
// - 0x03[2:0] torch and assist current code.
// - 0x04[7:6] inductor peak current limit.
// - 0x04[5] strobe edge or level sensitive.
// - 0x04[4] permits the torch pin.
// - 0x04[3] switches the LED current output.
// - 0x04[2] enables the strobe pin.
// - 0x04[1:0] standby, assist or flash mode.
// - 0x05 read-only fault flags reset to zero.
// - 0x05[3] writable LED count, default two.
// - 0x06[2] strobe trigger polarity.
// - 0x06[1] lets transmit mask reduce flash current.
// - Any fault shuts output and sets flag.
// - Host reading fault register clears its flags.
// - Stay disabled until fault flags cleared.
// - Answer bus address bytes 0x60 and 0x61.
// - Subaddress auto-increments after each data byte.
// - Undervoltage reset restores all register defaults.
// - 0x04[3] enables LED-count detection at start.
`timescale 1ns/10ps
`default_nettype none

module flr_ctrl_regs #(
    parameter logic [7:0] P_DESIGN_ID  = 8'h5a, // Arbitrary value.
    parameter logic [7:0] P_SI_REV     = 8'h0c, // Arbitrary value.
    parameter int         P_CYC_PER_MS = flr_pkg::FLR_CYC_PER_MS
) (
    // Clock and undervoltage reset.
    input  wire logic            i_clk_sys,
    input  wire logic            i_rst_b,
    // Serial bus, doubling as ctrl_pin_a and ctrl_pin_b.
    input  wire logic            i_scl,
    input  wire logic            i_sda,
    output logic                 o_sda,
    output logic                 o_sda_oe,
    // Mode select and light request pins.
    input  wire logic            i_bus_mode,
    input  wire logic            i_strobe,
    input  wire logic            i_torch,
    input  wire logic            i_tx_mask,
    // Analog fault and forward voltage comparators.
    input  wire logic            i_flt_ovp,
    input  wire logic            i_flt_short,
    input  wire logic            i_flt_otemp,
    input  wire logic            i_flt_ilim,
    input  wire logic            i_vf_high,
    // Control of the LED current output.
    output flr_pkg::flr_drive_type o_drive,
    output logic                 o_shutdown
);
    import flr_pkg::*;

    // ==========================================================
    // Pin synchronisation and edge detection.
    logic [FLR_SYNC_W-1:0] pin;
    logic                  scl;
    logic                  sda;
    logic                  bus_on;
    logic                  scl_p_q;
    logic                  sda_p_q;
    logic                  stb_p_q;
    logic                  start;
    logic                  stop;
    logic                  rise;
    logic                  fall;
    logic                  stb_act;
    logic                  stb_edge;

    flr_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_d       ({i_vf_high, i_flt_ilim, i_flt_otemp, i_flt_short,
                     i_flt_ovp, i_tx_mask, i_torch, i_strobe,
                     i_bus_mode, i_sda, i_scl}),
        .o_q       (pin)
    );

    assign scl    = pin[FLR_S_SCL];
    assign sda    = pin[FLR_S_SDA];
    assign bus_on = pin[FLR_S_BUS];

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            stb_p_q <= 1'b0;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda;
            stb_p_q <= stb_act;
        end
    end

    assign start = bus_on && scl && scl_p_q && sda_p_q && !sda;
    assign stop  = bus_on && scl && scl_p_q && !sda_p_q && sda;
    assign rise  = bus_on && scl && !scl_p_q;
    assign fall  = bus_on && !scl && scl_p_q;

    // ==========================================================
    // Registers.
    logic [7:0] tmr_q;
    logic [7:0] cur_q;
    logic [7:0] out_q;
    logic [7:0] flt_q;
    logic [7:0] flt_d;
    logic [7:0] inp_q;
    logic [7:0] flt_set;
    logic       flt_any;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] ptr_q;
    logic [7:0] sh_q;
    logic [7:0] rd_data;
    logic       tmo_set;
    logic       sw_done;
    logic       det_stb;
    logic       pins_low;
    flr_light_type light_q;
    flr_light_type light_d;

    assign flt_any = |(flt_q & FLR_FLT_MASK);

    // Reset is the undervoltage lockout, so every register returns home.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tmr_q <= FLR_RST_TMR;
            cur_q <= FLR_RST_CUR;
            inp_q <= FLR_RST_INP;
        end else if (wr_stb) begin
            unique case (ptr_q)
                FLR_ADR_TMR: tmr_q <= sh_q & FLR_WM_TMR;
                FLR_ADR_CUR: cur_q <= sh_q & FLR_WM_CUR;
                FLR_ADR_INP: inp_q <= sh_q & FLR_WM_INP;
                default: ;
            endcase
        end
    end

    // A completed software flash returns the mode field to standby.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_q <= FLR_RST_OUT;
        end else if (wr_stb && ptr_q == FLR_ADR_OUT) begin
            out_q <= sh_q & FLR_WM_OUT;
        end else if (sw_done) begin
            out_q[FLR_MODE_LSB+:2] <= FLR_MODE_STBY;
        end
    end

    // Fault flags: a new fault wins over a clear in the same cycle.
    assign flt_set = {pin[FLR_S_OVP], pin[FLR_S_SC], pin[FLR_S_OT],
                      tmo_set, 2'b00, pin[FLR_S_IL], 1'b0};
    assign pins_low = !bus_on && !scl && !sda && !pin[FLR_S_TORCH];

    always_comb begin
        flt_d = flt_q;
        if ((rd_stb && ptr_q == FLR_ADR_FLT) || pins_low) begin
            flt_d = flt_q & ~FLR_FLT_MASK;
        end
        if (wr_stb && ptr_q == FLR_ADR_FLT) begin
            flt_d[FLR_TWO_B] = sh_q[FLR_TWO_B];
        end
        if (det_stb) begin
            flt_d[FLR_TWO_B] = pin[FLR_S_VF];
        end
        flt_d = flt_d | (flt_set & FLR_FLT_MASK);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flt_q      <= FLR_RST_FLT;
            o_shutdown <= 1'b0;
        end else begin
            flt_q      <= flt_d;
            o_shutdown <= |(flt_d & FLR_FLT_MASK);
        end
    end

    always_comb begin
        unique case (ptr_q)
            FLR_ADR_ID:  rd_data = P_DESIGN_ID;
            FLR_ADR_REV: rd_data = P_SI_REV;
            FLR_ADR_TMR: rd_data = tmr_q;
            FLR_ADR_CUR: rd_data = cur_q;
            FLR_ADR_OUT: rd_data = out_q;
            FLR_ADR_FLT: rd_data = flt_q;
            FLR_ADR_INP: rd_data = inp_q;
            default:     rd_data = 8'h00;
        endcase
    end

    // ==========================================================
    // Serial bus slave.
    typedef enum logic [2:0] {
        BS_IDLE,
        BS_ADDR,
        BS_SUB,
        BS_WR,
        BS_RD
    } flr_bus_type;

    flr_bus_type bs_q;
    logic [3:0]  cnt_q;
    logic [7:0]  tx_q;
    logic        rd_q;
    logic        nack_q;

    assign wr_stb = fall && cnt_q == 4'h8 && bs_q == BS_WR;
    assign rd_stb = fall && cnt_q == 4'h9 &&
                    ((bs_q == BS_ADDR && rd_q) || (bs_q == BS_RD && !nack_q));
    assign o_sda  = 1'b0;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bs_q     <= BS_IDLE;
            cnt_q    <= 4'h0;
            sh_q     <= 8'h00;
            tx_q     <= 8'h00;
            ptr_q    <= 8'h00;
            rd_q     <= 1'b0;
            nack_q   <= 1'b0;
            o_sda_oe <= 1'b0;
        end else if (!bus_on || stop) begin
            bs_q     <= BS_IDLE;
            o_sda_oe <= 1'b0;
        end else if (start) begin
            bs_q     <= BS_ADDR;
            cnt_q    <= 4'h0;
            o_sda_oe <= 1'b0;
        end else if (rise && bs_q != BS_IDLE) begin
            if (cnt_q < 4'h8) begin
                sh_q  <= {sh_q[6:0], sda};
                cnt_q <= cnt_q + 4'h1;
            end else if (cnt_q == 4'h8) begin
                nack_q <= sda;
                cnt_q  <= 4'h9;
            end
        end else if (fall && bs_q != BS_IDLE) begin
            if (cnt_q == 4'h8) begin
                o_sda_oe <= 1'b1;
                unique case (bs_q)
                    BS_ADDR: begin
                        rd_q <= (sh_q == FLR_DEV_RD);
                        if (sh_q != FLR_DEV_WR && sh_q != FLR_DEV_RD) begin
                            bs_q     <= BS_IDLE;
                            o_sda_oe <= 1'b0;
                        end
                    end
                    BS_SUB: ptr_q <= sh_q;
                    BS_WR:  ptr_q <= ptr_q + 8'h1;
                    BS_RD:  o_sda_oe <= 1'b0;
                    default: ;
                endcase
            end else if (cnt_q == 4'h9) begin
                cnt_q    <= 4'h0;
                o_sda_oe <= 1'b0;
                if (rd_stb) begin
                    bs_q     <= BS_RD;
                    tx_q     <= rd_data;
                    o_sda_oe <= !rd_data[7];
                    ptr_q    <= ptr_q + 8'h1;
                end else if (bs_q == BS_ADDR) begin
                    bs_q <= BS_SUB;
                end else if (bs_q == BS_SUB) begin
                    bs_q <= BS_WR;
                end else if (bs_q == BS_RD) begin
                    bs_q <= BS_IDLE;
                end
            end else if (bs_q == BS_RD && cnt_q != 4'h0) begin
                tx_q     <= {tx_q[6:0], 1'b0};
                o_sda_oe <= !tx_q[6];
            end
        end
    end

    // ==========================================================
    // Light control.
    logic [1:0]  mode;
    logic        stb_en;
    logic        lvl;
    logic        two;
    logic        flash_go;
    logic        tmr_done;
    logic        reduce;
    logic [31:0] tmr_ms;
    logic [31:0] tmr_lim;
    flr_light_type base;

    assign mode     = out_q[FLR_MODE_LSB+:2];
    assign stb_en   = out_q[FLR_STB_B];
    assign lvl      = out_q[FLR_LVL_B];
    assign two      = flt_q[FLR_TWO_B];
    assign stb_act  = pin[FLR_S_STB] ~^ inp_q[FLR_POL_B];
    assign stb_edge = stb_act && !stb_p_q;
    assign flash_go = mode == FLR_MODE_FLASH &&
                      (!stb_en || (lvl ? stb_act : stb_edge));
    assign tmr_ms   = bus_on ? FLR_TMR_BASE_MS + FLR_TMR_STEP_MS *
                      int'(tmr_q[FLR_TMR_LSB+:4]) : FLR_LOGIC_TMO_MS;
    assign tmr_lim  = 32'(tmr_ms * P_CYC_PER_MS);

    flr_flash_timer u_timer (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_run     (light_q == LT_FLASH),
        .i_limit   (tmr_lim),
        .o_done    (tmr_done)
    );

    always_comb begin
        if (mode == FLR_MODE_ASSIST || (mode == FLR_MODE_FLASH && stb_en)) begin
            base = LT_ASSIST;
        end else if (pin[FLR_S_TORCH] && out_q[FLR_TORCH_B]) begin
            base = LT_TORCH;
        end else begin
            base = LT_OFF;
        end
    end

    always_comb begin
        light_d = LT_OFF;
        tmo_set = 1'b0;
        sw_done = 1'b0;
        if (flt_any) begin
            light_d = LT_OFF;
        end else if (bus_on) begin
            if (light_q != LT_FLASH) begin
                light_d = flash_go ? LT_FLASH : base;
            end else if (mode != FLR_MODE_FLASH) begin
                light_d = base;
            end else if (tmr_done) begin
                light_d = base;
                tmo_set = stb_en && lvl;
                sw_done = !stb_en;
            end else if (stb_en && lvl && !stb_act) begin
                light_d = base;
            end else begin
                light_d = LT_FLASH;
            end
        end else begin
            unique case ({scl, sda})
                2'b11: begin
                    light_d = tmr_done ? LT_OFF : LT_FLASH;
                    tmo_set = tmr_done;
                end
                2'b01: light_d = LT_ASSIST;
                2'b00: light_d = pin[FLR_S_TORCH] ? LT_TORCH : LT_OFF;
                2'b10: light_d = LT_OFF;
            endcase
        end
    end

    assign det_stb = bus_on && out_q[FLR_OUTON_B] &&
                     light_q == LT_OFF && light_d != LT_OFF;
    assign reduce  = light_d == LT_FLASH && pin[FLR_S_TXM] &&
                     (!bus_on || inp_q[FLR_TXM_B]);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            light_q <= LT_OFF;
            o_drive <= '0;
        end else begin
            light_q        <= light_d;
            o_drive.light  <= light_d;
            o_drive.on     <= light_d != LT_OFF &&
                              (!bus_on || out_q[FLR_OUTON_B]);
            o_drive.ilim   <= out_q[FLR_ILIM_LSB+:2];
            o_drive.vref   <= tmr_q[FLR_VREF_LSB+:2];
            o_drive.reduce <= reduce;
            if (light_d == LT_FLASH && !reduce) begin
                o_drive.i_code <= bus_on ? cur_q[FLR_FLI_LSB+:4] :
                                  (two ? FLR_LG_FL_TWO : FLR_LG_FL_ONE);
            end else begin
                o_drive.i_code <= {1'b0, bus_on ? cur_q[FLR_TRI_LSB+:3] :
                                  (two ? FLR_LG_TR_TWO : FLR_LG_TR_ONE)};
            end
        end
    end

endmodule

`default_nettype wire

// *** src/flr_pkg.sv ***
package flr_pkg;

    // ==========================================================
    // Timing.
    localparam int FLR_CLK_PERIOD_NS = 5;
    localparam int FLR_CYC_PER_MS    = 1000000 / FLR_CLK_PERIOD_NS;
    localparam int FLR_TMR_BASE_MS   = 100;
    localparam int FLR_TMR_STEP_MS   = 50;
    localparam int FLR_LOGIC_TMO_MS  = 850;

    // ==========================================================
    // Serial bus addressing.
    localparam logic [7:0] FLR_DEV_WR = 8'h60;
    localparam logic [7:0] FLR_DEV_RD = 8'h61;
    localparam logic [7:0] FLR_ADR_ID   = 8'h00;
    localparam logic [7:0] FLR_ADR_REV  = 8'h01;
    localparam logic [7:0] FLR_ADR_TMR  = 8'h02;
    localparam logic [7:0] FLR_ADR_CUR  = 8'h03;
    localparam logic [7:0] FLR_ADR_OUT  = 8'h04;
    localparam logic [7:0] FLR_ADR_FLT  = 8'h05;
    localparam logic [7:0] FLR_ADR_INP  = 8'h06;

    // ==========================================================
    // Reset values and writable bit masks.
    localparam logic [7:0] FLR_RST_TMR = 8'h0f;
    localparam logic [7:0] FLR_RST_CUR = 8'h61;
    localparam logic [7:0] FLR_RST_OUT = 8'hb4;
    localparam logic [7:0] FLR_RST_FLT = 8'h08;
    localparam logic [7:0] FLR_RST_INP = 8'h06;
    localparam logic [7:0] FLR_WM_TMR  = 8'h3f;
    localparam logic [7:0] FLR_WM_CUR  = 8'hf7;
    localparam logic [7:0] FLR_WM_OUT  = 8'hff;
    localparam logic [7:0] FLR_WM_FLT  = 8'h08;
    localparam logic [7:0] FLR_WM_INP  = 8'h06;
    localparam logic [7:0] FLR_FLT_MASK = 8'hf2;

    // ==========================================================
    // Field positions.
    localparam int FLR_VREF_LSB = 4;
    localparam int FLR_TMR_LSB  = 0;
    localparam int FLR_FLI_LSB  = 4;
    localparam int FLR_TRI_LSB  = 0;
    localparam int FLR_ILIM_LSB = 6;
    localparam int FLR_LVL_B    = 5;
    localparam int FLR_TORCH_B  = 4;
    localparam int FLR_OUTON_B  = 3;
    localparam int FLR_STB_B    = 2;
    localparam int FLR_MODE_LSB = 0;
    localparam int FLR_OVP_B    = 7;
    localparam int FLR_SC_B     = 6;
    localparam int FLR_OT_B     = 5;
    localparam int FLR_TMO_B    = 4;
    localparam int FLR_TWO_B    = 3;
    localparam int FLR_IL_B     = 1;
    localparam int FLR_POL_B    = 2;
    localparam int FLR_TXM_B    = 1;

    // ==========================================================
    // Output modes and fixed currents of the two-pin mode.
    localparam logic [1:0] FLR_MODE_STBY   = 2'h0;
    localparam logic [1:0] FLR_MODE_ASSIST = 2'h2;
    localparam logic [1:0] FLR_MODE_FLASH  = 2'h3;
    localparam logic [3:0] FLR_LG_FL_ONE   = 4'hf;
    localparam logic [3:0] FLR_LG_FL_TWO   = 4'h6;
    localparam logic [2:0] FLR_LG_TR_ONE   = 3'h3;
    localparam logic [2:0] FLR_LG_TR_TWO   = 3'h1;

    // ==========================================================
    // Pin synchroniser lanes.
    localparam int FLR_SYNC_W  = 11;
    localparam int FLR_S_SCL   = 0;
    localparam int FLR_S_SDA   = 1;
    localparam int FLR_S_BUS   = 2;
    localparam int FLR_S_STB   = 3;
    localparam int FLR_S_TORCH = 4;
    localparam int FLR_S_TXM   = 5;
    localparam int FLR_S_OVP   = 6;
    localparam int FLR_S_SC    = 7;
    localparam int FLR_S_OT    = 8;
    localparam int FLR_S_IL    = 9;
    localparam int FLR_S_VF    = 10;

    typedef enum logic [1:0] {
        LT_OFF,
        LT_ASSIST,
        LT_TORCH,
        LT_FLASH
    } flr_light_type;

    typedef struct packed {
        logic          on;
        flr_light_type light;
        logic [3:0]    i_code;
        logic [1:0]    ilim;
        logic [1:0]    vref;
        logic          reduce;
    } flr_drive_type;

endpackage

// *** src/flr_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module flr_sync (
    // Clock and reset.
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_rst_b,
    // Asynchronous inputs and their synchronised copies.
    input  wire logic [flr_pkg::FLR_SYNC_W-1:0] i_d,
    output logic      [flr_pkg::FLR_SYNC_W-1:0] o_q
);
    import flr_pkg::*;

    logic [FLR_SYNC_W-1:0] meta_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end

endmodule

`default_nettype wire

// *** src/flr_flash_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module flr_flash_timer (
    // Clock and reset.
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    // Run level, limit in cycles, expiry level.
    input  wire logic        i_run,
    input  wire logic [31:0] i_limit,
    output logic             o_done
);
    import flr_pkg::*;

    logic [31:0] cnt_q;

    // The count restarts whenever the run level drops.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 32'h0;
        end else if (!i_run) begin
            cnt_q <= 32'h0;
        end else if (cnt_q != i_limit) begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    assign o_done = i_run && (cnt_q == i_limit);

endmodule

`default_nettype wire

// *** verif/flr_ctrl_regs_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module flr_ctrl_regs_checker (
    // Clock and reset.
    input wire logic                   i_clk_sys,
    input wire logic                   i_rst_b,
    // Pins watched.
    input wire logic                   i_scl,
    input wire logic                   i_sda,
    input wire logic                   i_bus_mode,
    input wire logic                   i_torch,
    input wire logic                   i_flt_ovp,
    input wire logic                   i_flt_short,
    input wire logic                   i_flt_otemp,
    input wire logic                   i_flt_ilim,
    input wire logic                   o_sda,
    input wire logic                   o_sda_oe,
    input wire flr_pkg::flr_drive_type o_drive,
    input wire logic                   o_shutdown
);
    import flr_pkg::*;
    // ==================================================
    // Properties.
    wire logic any_flt = i_flt_ovp | i_flt_short | i_flt_otemp | i_flt_ilim;
    wire logic pins_lo = !i_bus_mode & !i_scl & !i_sda & !i_torch & !any_flt;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence s_fault;
        any_flt;
    endsequence
    sequence s_quiet;
        pins_lo [*6];
    endsequence
    AST_SDA_LOW: assert property (o_sda == 1'b0)
        else $error("sda data value not low");
    AST_FLT_SHUT: assert property (s_fault |-> ##[1:6] o_shutdown)
        else $error("fault pin without shutdown");
    AST_SHUT_DARK: assert property (
        o_shutdown [*2] |-> o_drive.light == LT_OFF)
        else $error("light on during shutdown");
    AST_RST_QUIET: assert property (
        $rose(i_rst_b) |-> !o_sda_oe && !o_shutdown && o_drive == '0)
        else $error("outputs active after reset");
    AST_RST_CFG: assert property (
        $rose(i_rst_b) |-> ##3 o_drive.ilim == 2'h2 && o_drive.vref == 2'h0)
        else $error("limit or reference not default");
    AST_ACK_HOLD: assert property (
        $rose(i_scl) |-> $stable(o_sda_oe) [*8])
        else $error("sda pull changed while clock high");
    AST_LOGIC_QUIET: assert property (
        !i_bus_mode [*8] |-> !o_sda_oe)
        else $error("bus answered in two-pin mode");
    AST_LOGIC_CLR: assert property (s_quiet |-> !o_shutdown)
        else $error("fault not cleared by low pins");
endmodule

`default_nettype wire

// *** verif/flr_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module flr_host_model (
    // Clock and bus line.
    input  wire logic i_clk_sys,
    input  wire logic i_sda_line,
    output var logic  o_scl,
    output var logic  o_sda
);
    // ==================================================
    // Serial bus master, one bit per 125 ns.
    logic [7:0] rbuf [8];
    logic [7:0] wbuf [8];
    logic       nack;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic set_pins(input logic a, input logic b);
        o_scl = a;
        o_sda = b;
    endtask
    task automatic bitx(input logic b, output logic r);
        o_scl = 1'b0;
        w(6);
        o_sda = b;
        w(7);
        o_scl = 1'b1;
        w(6);
        r = i_sda_line;
        w(6);
    endtask
    // Start is (1,0), stop is (0,1).
    task automatic cond(input logic a, input logic b);
        o_scl = 1'b0;
        w(6);
        o_sda = a;
        w(7);
        o_scl = 1'b1;
        w(12);
        o_sda = b;
        w(12);
    endtask
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(last, a);
        nack = a;
    endtask
    task automatic wr(input logic [7:0] a, input int n);
        logic [7:0] r;
        cond(1'b1, 1'b0);
        xfer(8'h60, 1'b1, r);
        xfer(a, 1'b1, r);
        for (int i = 0; i < n; i++) xfer(wbuf[i], 1'b1, r);
        cond(1'b0, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] r;
        cond(1'b1, 1'b0);
        xfer(8'h60, 1'b1, r);
        xfer(a, 1'b1, r);
        cond(1'b1, 1'b0);
        xfer(8'h61, 1'b1, r);
        for (int i = 0; i < n; i++) xfer(8'hff, i == n - 1, rbuf[i]);
        cond(1'b0, 1'b1);
    endtask
endmodule

`default_nettype wire

// *** verif/flr_ctrl_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module flr_ctrl_regs_tb;
    import flr_pkg::*;
    // ==================================================
    // Bench signals and checking.
    localparam logic [7:0] ID  = 8'h3c; // Arbitrary value.
    localparam logic [7:0] REV = 8'h4d; // Arbitrary value.
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic bus_mode = 1'b1;
    logic vf = 1'b0;
    logic stb = 1'b0, trc = 1'b0, txm = 1'b0;
    logic [3:0] flt = 4'h0;
    logic scl, sda_m, oe, sda_o, shut, two;
    flr_drive_type drive;
    wire logic sda_line = sda_m & (oe ? sda_o : 1'b1);
    int error_cnt = 0;
    int n_compared = 0;
    int fcyc = 0;
    logic [4:0] fcode;
    logic [7:0] exp_q [$];
    logic [7:0] got, exp_v, cur;
    logic [31:0] seed = 32'h9f4bfafa;
    event res_ev;
    always #2.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (drive.light == LT_FLASH) begin
        fcyc++;
        fcode = {drive.on, drive.i_code};
    end
    always @(res_ev) begin
        exp_v = exp_q.pop_front();
        `CMP(got, exp_v)
    end
    flr_host_model h (.i_clk_sys(i_clk_sys), .i_sda_line(sda_line),
        .o_scl(scl), .o_sda(sda_m));
    flr_ctrl_regs #(.P_DESIGN_ID(ID), .P_SI_REV(REV), .P_CYC_PER_MS(20)) uut (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(scl),
        .i_sda(sda_line), .o_sda(sda_o), .o_sda_oe(oe),
        .i_bus_mode(bus_mode), .i_strobe(stb), .i_torch(trc),
        .i_tx_mask(txm), .i_flt_ovp(flt[0]), .i_flt_short(flt[1]),
        .i_flt_otemp(flt[2]), .i_flt_ilim(flt[3]), .i_vf_high(vf),
        .o_drive(drive), .o_shutdown(shut));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic put(input logic [7:0] g);
        got = g;
        -> res_ev;
        @(negedge i_clk_sys);
    endtask
    task automatic rdchk(input logic [7:0] a, input int n);
        h.rd(a, n);
        for (int i = 0; i < n; i++) put(h.rbuf[i]);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        logic [7:0] d [8];
        logic [7:0] fb [4];
        fb = '{8'h80, 8'h40, 8'h20, 8'h02};
        wait_n(8);
        i_rst_b = 1'b1;
        wait_n(8);
        d = '{ID, REV, 8'h0f, 8'h61, 8'hb4, 8'h08, 8'h06, 8'h00};
        for (int i = 0; i < 8; i++) exp_q.push_back(d[i]);
        rdchk(8'h00, 8);
        $display("defaults test done");
        for (int i = 0; i < 7; i++) h.wbuf[i] = rnd();
        h.wbuf[4][1:0] = 2'h0;
        h.wr(8'h00, 7);
        cur = h.wbuf[3];
        two = h.wbuf[5][3];
        d = '{ID, REV, h.wbuf[2] & 8'h3f, cur & 8'hf7, h.wbuf[4],
              h.wbuf[5] & 8'h08, h.wbuf[6] & 8'h06, 8'h00};
        for (int i = 0; i < 8; i++) exp_q.push_back(d[i]);
        rdchk(8'h00, 8);
        exp_q.push_back({6'h0, h.wbuf[4][7:6]});
        put({6'h0, drive.ilim});
        exp_q.push_back({6'h0, h.wbuf[2][5:4]});
        put({6'h0, drive.vref});
        h.cond(1'b1, 1'b0);
        h.xfer(8'h62, 1'b1, d[0]);
        h.cond(1'b0, 1'b1);
        exp_q.push_back(8'h01);
        put({7'h0, h.nack});
        $display("map test done");
        for (int k = 0; k < 4; k++) begin
            flt[k] = 1'b1;
            wait_n(2);
            flt[k] = 1'b0;
            wait_n(8);
            exp_q.push_back(8'h01);
            put({7'h0, shut});
            exp_q.push_back(fb[k] | {4'h0, two, 3'h0});
            rdchk(8'h05, 1);
            exp_q.push_back({4'h0, two, 3'h0});
            rdchk(8'h05, 1);
            exp_q.push_back(8'h00);
            put({7'h0, shut});
        end
        bus_mode = 1'b0;
        flt[1] = 1'b1;
        wait_n(2);
        flt[1] = 1'b0;
        wait_n(8);
        exp_q.push_back(8'h01);
        put({7'h0, shut});
        h.set_pins(1'b0, 1'b0);
        wait_n(10);
        exp_q.push_back(8'h00);
        put({7'h0, shut});
        bus_mode = 1'b1;
        h.set_pins(1'b0, 1'b1);
        wait_n(4);
        h.set_pins(1'b1, 1'b1);
        wait_n(8);
        $display("fault test done");
        d[0] = rnd();
        vf = d[0][0];
        h.wbuf[0] = 8'h00;
        h.wr(8'h02, 1);
        fcyc = 0;
        h.wbuf[0] = 8'h8b;
        h.wr(8'h04, 1);
        for (int i = 0; i < 4000 && (fcyc == 0 || drive.light == LT_FLASH); i++)
            wait_n(1);
        {stb, trc, txm} = 3'h7;
        exp_q.push_back(8'h01);
        put({7'h0, fcyc >= 1990 && fcyc <= 2010});
        exp_q.push_back({4'h1, cur[7:4]});
        put({3'h0, fcode});
        exp_q.push_back(8'h88);
        exp_q.push_back({4'h0, vf, 3'h0});
        rdchk(8'h04, 2);
        exp_q.push_back(8'h00);
        put({6'h0, drive.light});
        $display("flash test done");
        stop_test();
    end
endmodule

bind flr_ctrl_regs flr_ctrl_regs_checker chk (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_scl(i_scl), .i_sda(i_sda), .i_torch(i_torch),
    .i_bus_mode(i_bus_mode), .i_flt_ovp(i_flt_ovp), .o_sda(o_sda),
    .i_flt_short(i_flt_short), .i_flt_otemp(i_flt_otemp),
    .i_flt_ilim(i_flt_ilim), .o_sda_oe(o_sda_oe), .o_drive(o_drive),
    .o_shutdown(o_shutdown));

`default_nettype wire
